// ---- hdl/nasd_top.sv ----
// Node address strap decoder: strap capture, mode select, status and APB.
//
// Our own choices: the address map and the APB interface to the registers.
`timescale 1ns/100ps
`include "nasd_params.svh"

module nasd_top #(
  parameter int SETTLE_CYCLES = `NASD_SETTLE_CYCLES,
  parameter int FLASH_CYCLES  = `NASD_FLASH_CYCLES
) (
  input  wire logic                           sys_clk,
  input  wire logic                           rst_b,
  // Sensed strap levels in millivolts.
  input  wire logic [`NASD_LEVEL_WIDTH-1:0]   strap_select_low,
  input  wire logic [`NASD_LEVEL_WIDTH-1:0]   strap_select_mid,
  input  wire logic [`NASD_LEVEL_WIDTH-1:0]   strap_select_high,
  // Error condition from the drive core, same clock.
  input  wire logic                           drive_error,
  // APB slave.
  input  wire logic                           psel,
  input  wire logic                           penable,
  input  wire logic                           pwrite,
  input  wire logic [7:0]                     paddr,
  input  wire logic [31:0]                    pwdata,
  output logic      [31:0]                    prdata,
  output logic                                pready,
  output logic                                pslverr,
  // Status outputs.
  output logic                                drive_ready_output,
  output logic                                drive_fault_output,
  output logic      [7:0]                     node_address,
  output logic                                vendor_can_mode,
  output logic                                lss_inactive,
  output logic                                irq
);

  // ========================================================================
  // Declarations.
  nasd_pkg::nasd_code_type  code_low;
  nasd_pkg::nasd_code_type  code_mid;
  nasd_pkg::nasd_code_type  code_high;
  nasd_pkg::nasd_value_type live_value;
  nasd_pkg::nasd_value_type node_value;
  nasd_pkg::nasd_state_type state;
  logic [31:0]              settle_count;
  logic [31:0]              flash_count;
  logic                     flash_phase;
  logic                     init_done;
  logic                     default_id;
  logic                     fault;
  logic                     fault_q;
  logic                     strap_mismatch;
  logic [`NASD_EV_WIDTH-1:0] events;
  logic [`NASD_EV_WIDTH-1:0] status;
  logic [`NASD_EV_WIDTH-1:0] mask;
  logic [`NASD_EV_WIDTH-1:0] read_clear;
  logic                     setup_phase;
  logic                     access_phase;
  logic                     addr_hit;
  logic                     wr_ctrl;
  logic                     wr_mask;
  logic                     rd_status;
  logic [31:0]              next_prdata;
  logic [8:0]               raw_value;
  logic [7:0]               next_address;

  // ========================================================================
  // Quantisers, one per selection input.
  nasd_quantizer u_q_low (
    .sys_clk  (sys_clk),
    .rst_b    (rst_b),
    .level_mv (strap_select_low),
    .code     (code_low)
  );

  nasd_quantizer u_q_mid (
    .sys_clk  (sys_clk),
    .rst_b    (rst_b),
    .level_mv (strap_select_mid),
    .code     (code_mid)
  );

  nasd_quantizer u_q_high (
    .sys_clk  (sys_clk),
    .rst_b    (rst_b),
    .level_mv (strap_select_high),
    .code     (code_high)
  );

  // Assemble the live value from the three codes.
  always_comb begin
    live_value.low  = code_low;
    live_value.mid  = code_mid;
    live_value.high = code_high;
  end

  // ========================================================================
  // Start-up sequencer: wait for the strap levels to settle, then latch.
  // Latching once avoids the address moving under a running network.
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      state        <= nasd_pkg::NASD_SETTLE;
      settle_count <= 32'h0;
    end else begin
      case (state)
        nasd_pkg::NASD_SETTLE: begin
          if (settle_count >= 32'(SETTLE_CYCLES - 1)) begin
            state <= nasd_pkg::NASD_LATCH;
          end else begin
            settle_count <= settle_count + 32'h1;
          end
        end
        nasd_pkg::NASD_LATCH: begin
          state <= nasd_pkg::NASD_RUN;
        end
        nasd_pkg::NASD_RUN: begin
          state <= nasd_pkg::NASD_RUN;
        end
        default: begin
          state <= nasd_pkg::NASD_SETTLE;
        end
      endcase
    end
  end

  // Latched node value, taken once in the latch state.
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      node_value <= '0;
    end else if (state == nasd_pkg::NASD_LATCH) begin
      node_value <= live_value;
    end
  end

  assign init_done = (state == nasd_pkg::NASD_RUN);

  // Grounded or open straps all read as code zero.
  assign default_id = (node_value == '0);

  // ========================================================================
  // Address arithmetic: 64*high - 128 + 8*mid + low kept to seven bits.
  // Subtracting 128 never touches bits 6..0, so bit 8 and bit 7 drop out.
  always_comb begin
    raw_value    = node_value;
    next_address = {1'b0, raw_value[6:0]};
    if (default_id) begin
      next_address = `NASD_DEFAULT_ADDR;
    end
  end

  // Registered address and mode outputs.
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      node_address    <= `NASD_DEFAULT_ADDR;
      vendor_can_mode <= 1'b0;
      lss_inactive    <= 1'b0;
    end else begin
      node_address    <= next_address;
      // Bit 7 picks the protocol; the default case forces CANopen.
      vendor_can_mode <= raw_value[7] && !default_id;
      lss_inactive    <= init_done && default_id;
    end
  end

  // ========================================================================
  // Error tracking: a drive error or a strap that moves after latching.
  assign strap_mismatch = init_done && (live_value != node_value);

  // Fault stays until cleared; a new error in the clear cycle wins.
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      fault <= 1'b0;
    end else if (drive_error || strap_mismatch) begin
      fault <= 1'b1;
    end else if (wr_ctrl && pwdata[`NASD_CTRL_FAULT_CLR]) begin
      fault <= 1'b0;
    end
  end

  // ========================================================================
  // One-second flash timer, running only in the default case.
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      flash_count <= 32'h0;
      flash_phase <= 1'b0;
    end else if (!(init_done && default_id)) begin
      flash_count <= 32'h0;
      flash_phase <= 1'b0;
    end else if (flash_count >= 32'(FLASH_CYCLES - 1)) begin
      flash_count <= 32'h0;
      flash_phase <= !flash_phase;
    end else begin
      flash_count <= flash_count + 32'h1;
    end
  end

  // Ready and fault outputs.
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      drive_ready_output <= 1'b0;
      drive_fault_output <= 1'b0;
    end else begin
      drive_fault_output <= fault || drive_error;
      if (!init_done || fault || drive_error) begin
        drive_ready_output <= 1'b0;
      end else if (default_id) begin
        drive_ready_output <= flash_phase;
      end else begin
        drive_ready_output <= 1'b1;
      end
    end
  end

  // ========================================================================
  // Events: init done, fault rising, strap moved.
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      fault_q <= 1'b0;
    end else begin
      fault_q <= fault;
    end
  end

  always_comb begin
    events                  = '0;
    events[`NASD_EV_INIT]   = (state == nasd_pkg::NASD_LATCH);
    events[`NASD_EV_FAULT]  = fault && !fault_q;
    events[`NASD_EV_STRAP]  = strap_mismatch;
  end

  // Sticky status; a read clears only the bits it returned, so an event
  // landing between setup and access is never lost, and set beats clear.
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      status <= '0;
    end else begin
      status <= (status & ~read_clear) | events;
    end
  end

  assign read_clear = rd_status ? prdata[`NASD_EV_WIDTH-1:0] : '0;

  // Level interrupt from unmasked status bits.
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      irq <= 1'b0;
    end else begin
      irq <= |(((status & ~read_clear) | events) & mask);
    end
  end

  // ========================================================================
  // APB decode. Zero wait states; data is staged in the setup cycle.
  assign setup_phase  = psel && !penable;
  assign access_phase = psel && penable;
  assign addr_hit     = (paddr == `NASD_OFS_NODE_ADDR) ||
                        (paddr == `NASD_OFS_STATUS)    ||
                        (paddr == `NASD_OFS_MASK)      ||
                        (paddr == `NASD_OFS_CTRL);
  assign wr_ctrl      = access_phase && pwrite && (paddr == `NASD_OFS_CTRL);
  assign wr_mask      = access_phase && pwrite && (paddr == `NASD_OFS_MASK);
  assign rd_status    = access_phase && !pwrite && (paddr == `NASD_OFS_STATUS);
  assign pready       = 1'b1;
  assign pslverr      = access_phase && !addr_hit;

  // Mask register.
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      mask <= `NASD_MASK_RESET;
    end else if (wr_mask) begin
      mask <= pwdata[`NASD_EV_WIDTH-1:0];
    end
  end

  // Read mux; unmapped addresses read zero.
  always_comb begin
    next_prdata = 32'h0;
    case (paddr)
      `NASD_OFS_NODE_ADDR: begin
        next_prdata[`NASD_NODE_VALUE_MSB:0] = node_value;
        next_prdata[`NASD_NODE_MODE_BIT]    = vendor_can_mode;
        next_prdata[`NASD_NODE_LSS_BIT]     = lss_inactive;
        next_prdata[`NASD_NODE_DFLT_BIT]    = init_done;
        next_prdata[`NASD_NODE_ADDR_MSB:`NASD_NODE_ADDR_LSB] = node_address;
      end
      `NASD_OFS_STATUS: begin
        next_prdata[`NASD_EV_WIDTH-1:0] = status | events;
      end
      `NASD_OFS_MASK: begin
        next_prdata[`NASD_EV_WIDTH-1:0] = mask;
      end
      `NASD_OFS_CTRL: begin
        next_prdata[`NASD_CTRL_FAULT_CLR] = fault;
      end
      default: begin
        next_prdata = 32'h0;
      end
    endcase
  end

  // Read data register, loaded in the setup cycle and held through access.
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      prdata <= 32'h0;
    end else if (setup_phase) begin
      prdata <= next_prdata;
    end
  end

endmodule

// ---- hdl/nasd_params.svh ----
// Constants of the node address strap decoder: offsets, fields, resets, timing.
`ifndef NASD_PARAMS_SVH
`define NASD_PARAMS_SVH

// ==========================================================================
// Register offsets (byte addresses).
`define NASD_OFS_NODE_ADDR   8'h00
`define NASD_OFS_STATUS      8'h04
`define NASD_OFS_MASK        8'h08
`define NASD_OFS_CTRL        8'h0C

// ==========================================================================
// Field positions.
`define NASD_NODE_VALUE_MSB  8
`define NASD_NODE_MODE_BIT   9
`define NASD_NODE_LSS_BIT    10
`define NASD_NODE_DFLT_BIT   11
`define NASD_NODE_ADDR_LSB   16
`define NASD_NODE_ADDR_MSB   23
`define NASD_EV_INIT         0
`define NASD_EV_FAULT        1
`define NASD_EV_STRAP        2
`define NASD_CTRL_FAULT_CLR  0

// ==========================================================================
// Reset and fixed values.
`define NASD_EV_WIDTH        3
`define NASD_MASK_RESET      3'h0
`define NASD_DEFAULT_ADDR    8'hFF
`define NASD_LEVEL_WIDTH     12

// Band thresholds in millivolts, rising.
`define NASD_THR_1           12'd530
`define NASD_THR_2           12'd1410
`define NASD_THR_3           12'd2010
`define NASD_THR_4           12'd2430
`define NASD_THR_5           12'd2750
`define NASD_THR_6           12'd3010
`define NASD_THR_7           12'd3220

// ==========================================================================
// Timing.
`define NASD_CLK_HZ          10000000
`define NASD_SETTLE_US       1000
`define NASD_SETTLE_CYCLES   ((`NASD_SETTLE_US * (`NASD_CLK_HZ / 1000000)))
`define NASD_FLASH_S         1
`define NASD_FLASH_CYCLES    ((`NASD_FLASH_S * `NASD_CLK_HZ))

`endif

// ---- hdl/nasd_pkg.sv ----
// Types shared by the node address strap decoder files.
package nasd_pkg;

  // ========================================================================
  // One strap code per selection input.
  typedef logic [2:0] nasd_code_type;

  // Assembled node-address value, high code in the top bits.
  typedef struct packed {
    nasd_code_type high;
    nasd_code_type mid;
    nasd_code_type low;
  } nasd_value_type;

  // Sequencer states.
  typedef enum logic [1:0] {
    NASD_SETTLE,
    NASD_LATCH,
    NASD_RUN
  } nasd_state_type;

endpackage

// ---- hdl/nasd_quantizer.sv ----
// Two-flop synchroniser and eight-band quantiser for one strap level.
`timescale 1ns/100ps
`include "nasd_params.svh"

module nasd_quantizer (
  input  wire logic                           sys_clk,
  input  wire logic                           rst_b,
  input  wire logic [`NASD_LEVEL_WIDTH-1:0]   level_mv,
  output nasd_pkg::nasd_code_type             code
);

  localparam logic [`NASD_LEVEL_WIDTH-1:0] THR [1:7] = '{
    `NASD_THR_1, `NASD_THR_2, `NASD_THR_3, `NASD_THR_4,
    `NASD_THR_5, `NASD_THR_6, `NASD_THR_7
  };

  logic [`NASD_LEVEL_WIDTH-1:0] meta_q;
  logic [`NASD_LEVEL_WIDTH-1:0] sync_q;
  logic [7:1]                   above;
  nasd_pkg::nasd_code_type      next_code;

  // ========================================================================
  // Synchroniser; straps are static, so a word-wide sync is acceptable.
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= level_mv;
      sync_q <= meta_q;
    end
  end

  // ========================================================================
  // One comparator per band edge gives a thermometer code.
  genvar gi;
  generate
    for (gi = 1; gi <= 7; gi++) begin : g_band
      assign above[gi] = (sync_q >= THR[gi]);
    end
  endgenerate

  // Count the edges passed; a level on an edge goes to the upper band.
  always_comb begin
    next_code = 3'h0;
    for (int i = 1; i <= 7; i++) begin
      if (above[i]) begin
        next_code = 3'(i);
      end
    end
  end

  // Registered code.
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      code <= 3'h0;
    end else begin
      code <= next_code;
    end
  end

endmodule

// ---- tb/nasd_top_asserts.sv ----
// Concurrent checks on the ports of the node address strap decoder.
`timescale 1ns/100ps

module nasd_top_asserts #(
  parameter int FLASH_CYCLES = 16
) (
  input wire logic       sys_clk,
  input wire logic       rst_b,
  input wire logic       drive_error,
  input wire logic       psel,
  input wire logic       penable,
  input wire logic [7:0] paddr,
  input wire logic       pslverr,
  input wire logic       drive_ready_output,
  input wire logic       drive_fault_output,
  input wire logic [7:0] node_address,
  input wire logic       vendor_can_mode,
  input wire logic       lss_inactive
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);

  // ==========================================================================
  // Flash timing helper.
  // The first interval after entering the default case is skipped on purpose.
  logic prev_ready;
  logic prev_lss;
  logic seen;
  int   since;
  logic chg;
  assign chg = drive_ready_output != prev_ready;
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      prev_ready <= 1'b0;
      prev_lss   <= 1'b0;
      seen       <= 1'b0;
      since      <= 0;
    end else begin
      prev_ready <= drive_ready_output;
      prev_lss   <= lss_inactive;
      seen       <= seen | (chg & prev_lss & lss_inactive);
      since      <= chg ? 0 : since + 1;
    end
  end

  // ==========================================================================
  // Assertions.
  a_fault_follows: assert property (drive_error |=> drive_fault_output)
    else $error("fault output missed an error");
  a_ready_drops: assert property (drive_error |=> !drive_ready_output)
    else $error("ready output stayed high on error");
  a_ready_clean: assert property (
    $rose(drive_ready_output) |-> !drive_fault_output)
    else $error("ready rose while faulted");
  a_addr_limit: assert property (node_address != 8'hFF |-> !node_address[7])
    else $error("node address above limit");
  a_default_mode: assert property (node_address == 8'hFF |-> !vendor_can_mode)
    else $error("default address not in CANopen mode");
  a_lss_default: assert property (
    lss_inactive |-> node_address == 8'hFF && !vendor_can_mode)
    else $error("lss inactive outside default case");
  a_flash_period: assert property (
    chg && prev_lss && lss_inactive && seen |-> since == FLASH_CYCLES - 1)
    else $error("ready flash period wrong");
  a_unmapped_err: assert property (psel && penable && paddr > 8'h0C |-> pslverr)
    else $error("unmapped access without error");
  a_addr_held: assert property (
    node_address != 8'hFF && $past(node_address) != 8'hFF |-> $stable(node_address))
    else $error("node address changed after latch");

  c_default: cover property (lss_inactive && seen);
  c_vendor:  cover property (vendor_can_mode);
  c_fault:   cover property (drive_fault_output);
  c_unmap:   cover property (pslverr);
endmodule

// ---- tb/nasd_strap_model.sv ----
// Strap resistor model: each fitted code becomes its nominal level in mV.
`timescale 1ns/100ps
`include "nasd_params.svh"

module nasd_strap_model (
  input  wire nasd_pkg::nasd_code_type      code_low,
  input  wire nasd_pkg::nasd_code_type      code_mid,
  input  wire nasd_pkg::nasd_code_type      code_high,
  output logic [`NASD_LEVEL_WIDTH-1:0]      level_low,
  output logic [`NASD_LEVEL_WIDTH-1:0]      level_mid,
  output logic [`NASD_LEVEL_WIDTH-1:0]      level_high
);
  // ==========================================================================
  // Nominal levels, each inside its band, so a level never sits on a band edge.
  function automatic logic [11:0] nominal(input nasd_pkg::nasd_code_type c);
    case (c)
      3'h0: return 12'h000;
      3'h1: return 12'h424;
      3'h2: return 12'h6E0;
      3'h3: return 12'h8CA;
      3'h4: return 12'hA28;
      3'h5: return 12'hB4A;
      3'h6: return 12'hC3A;
      default: return 12'hCF8;
    endcase
  endfunction

  // Code 0 stands for a grounded or unfitted strap.
  always_comb begin
    level_low  = nominal(code_low);
    level_mid  = nominal(code_mid);
    level_high = nominal(code_high);
  end
endmodule

// ---- tb/tb_nasd_top.sv ----
// Self-checking testbench of the node address strap decoder.
`timescale 1ns/100ps
`include "nasd_params.svh"

module tb_nasd_top;
  localparam int SETTLE = 8;
  localparam int FLASH  = 16;
  logic                    sys_clk = 1'b0;
  logic                    rst_b = 1'b0;
  logic                    drive_error = 1'b0;
  logic                    psel = 1'b0;
  logic                    penable = 1'b0;
  logic                    pwrite = 1'b0;
  logic [7:0]              paddr = 8'h00;
  logic [31:0]             pwdata = 32'h0;
  logic [31:0]             prdata;
  logic                    pready;
  logic                    pslverr;
  logic                    ready;
  logic                    fault;
  logic [7:0]              node;
  logic                    vendor;
  logic                    lss;
  logic                    irq;
  nasd_pkg::nasd_code_type c_low = 3'h0;
  nasd_pkg::nasd_code_type c_mid = 3'h0;
  nasd_pkg::nasd_code_type c_high = 3'h0;
  logic [11:0]             lv_low;
  logic [11:0]             lv_mid;
  logic [11:0]             lv_high;
  int                      num_errors = 0;
  int                      num_checks = 0;
  int                      cycles = 0;

  always #50 sys_clk = ~sys_clk;

  nasd_strap_model nasd_strap_model_inst (.code_low(c_low), .code_mid(c_mid),
    .code_high(c_high), .level_low(lv_low), .level_mid(lv_mid), .level_high(lv_high));

  nasd_top #(.SETTLE_CYCLES(SETTLE), .FLASH_CYCLES(FLASH)) nasd_top_inst (
    .sys_clk(sys_clk), .rst_b(rst_b), .strap_select_low(lv_low),
    .strap_select_mid(lv_mid), .strap_select_high(lv_high), .drive_error(drive_error),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .drive_ready_output(ready),
    .drive_fault_output(fault), .node_address(node), .vendor_can_mode(vendor),
    .lss_inactive(lss), .irq(irq));

  // ==========================================================================
  // Shared tasks.
  task automatic conclude;
    $display("checks %0d mismatches %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // A hung handshake ends the run here as a mismatch.
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 5000) begin
      num_errors++;
      conclude();
    end
  end

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
  endtask

  // One APB transfer; request held until pready is sampled high.
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rdat, output logic err);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge sys_clk);
    penable <= 1'b1;
    do @(posedge sys_clk); while (pready !== 1'b1);
    rdat = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge sys_clk);
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    logic e;
    apb(1'b0, a, 32'h0, d, e);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    logic [31:0] d;
    logic        e;
    apb(1'b1, a, v, d, e);
  endtask

  // Straps are fitted before reset is released, as on a real board.
  task automatic boot(input logic [2:0] h, input logic [2:0] m, input logic [2:0] l);
    c_high <= h;
    c_mid <= m;
    c_low <= l;
    rst_b <= 1'b0;
    cyc(10);
    rst_b <= 1'b1;
    cyc(SETTLE + 20);
  endtask

  // ==========================================================================
  // Scenarios.
  task automatic test_codes;
    logic [31:0] d;
    logic [2:0]  h;
    logic [2:0]  m;
    int          a;
    for (int c = 1; c < 8; c++) begin
      h = 3'(c);
      m = 3'(c * 3);
      boot(h, m, 3'(c));
      a = (64 * (h & 3'h3) - 128 + 8 * m + c) & 127;
      check("node_address", 32'(node), 32'(a));
      check("vendor_mode", 32'(vendor), 32'(h[1]));
      check("ready", 32'(ready), 32'h1);
      rd(`NASD_OFS_NODE_ADDR, d);
      check("node_value", 32'(d[7:0]), 32'({h[1:0], m, 3'(c)}));
      check("node_mode", 32'(d[9]), 32'(h[1]));
    end
    $display("test_codes done");
  endtask

  task automatic test_default;
    logic [31:0] d;
    logic        prev;
    int          n;
    boot(3'h0, 3'h0, 3'h0);
    check("default_addr", 32'(node), 32'hFF);
    check("default_mode", 32'(vendor), 32'h0);
    check("lss_inactive", 32'(lss), 32'h1);
    rd(`NASD_OFS_NODE_ADDR, d);
    check("node_lss", 32'(d[10]), 32'h1);
    n = 0;
    prev = ready;
    repeat (4 * FLASH) begin
      @(posedge sys_clk);
      if (ready !== prev) n++;
      prev = ready;
    end
    check("flash_toggles", 32'(n), 32'h4);
    $display("test_default done");
  endtask

  task automatic test_fault;
    logic [31:0] d;
    boot(3'h2, 3'h1, 3'h1);
    rd(`NASD_OFS_STATUS, d);
    check("status_init", 32'(d[0]), 32'h1);
    wr(`NASD_OFS_MASK, 32'h2);
    drive_error <= 1'b1;
    cyc(3);
    check("fault_on", 32'(fault), 32'h1);
    check("ready_off", 32'(ready), 32'h0);
    check("irq_on", 32'(irq), 32'h1);
    drive_error <= 1'b0;
    cyc(3);
    check("fault_sticky", 32'(fault), 32'h1);
    rd(`NASD_OFS_STATUS, d);
    check("status_fault", 32'(d[1]), 32'h1);
    cyc(2);
    check("irq_off", 32'(irq), 32'h0);
    wr(`NASD_OFS_CTRL, 32'h1);
    cyc(3);
    check("fault_clear", 32'(fault), 32'h0);
    check("ready_back", 32'(ready), 32'h1);
    c_low <= 3'h5;
    cyc(10);
    check("strap_fault", 32'(fault), 32'h1);
    check("strap_ready", 32'(ready), 32'h0);
    rd(`NASD_OFS_STATUS, d);
    check("status_strap", 32'(d[2]), 32'h1);
    rd(`NASD_OFS_MASK, d);
    check("mask_rw", d, 32'h2);
    $display("test_fault done");
  endtask

  task automatic test_apb;
    logic [31:0] d;
    logic        e;
    boot(3'h3, 3'h0, 3'h4);
    rd(`NASD_OFS_MASK, d);
    check("mask_reset", 32'(d[2:0]), 32'(`NASD_MASK_RESET));
    wr(`NASD_OFS_NODE_ADDR, 32'hFFFFFFFF);
    rd(`NASD_OFS_NODE_ADDR, d);
    check("node_ro", 32'(d[23:16]), 32'h44);
    apb(1'b0, 8'h10, 32'h0, d, e);
    check("unmapped_err", 32'(e), 32'h1);
    check("unmapped_data", d, 32'h0);
    check("pready", 32'(pready), 32'h1);
    $display("test_apb done");
  endtask

  initial begin
    @(posedge sys_clk);
    test_codes();
    test_default();
    test_fault();
    test_apb();
    conclude();
  end
endmodule

bind nasd_top nasd_top_asserts #(.FLASH_CYCLES(FLASH_CYCLES)) nasd_top_asserts_inst (
  .sys_clk(sys_clk), .rst_b(rst_b), .drive_error(drive_error), .psel(psel),
  .penable(penable), .paddr(paddr), .pslverr(pslverr),
  .drive_ready_output(drive_ready_output), .drive_fault_output(drive_fault_output),
  .node_address(node_address), .vendor_can_mode(vendor_can_mode),
  .lss_inactive(lss_inactive));
